//--- common/sysref_consts.svh
// constants for the reference capture and offset trim register bank
// assumes a 32-bit wishbone slave; register index times four is the byte address
`ifndef SYSREF_CONSTS_SVH
`define SYSREF_CONSTS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_TRIM_HIGH    10'h025
`define IDX_TRIM_LOW     10'h026
`define IDX_CLK_CTRL     10'h030
`define IDX_CLK_STATUS   10'h031
`define IDX_REF_DELAY    10'h032
`define IDX_ANALOG_MISC_CONTROL     10'h033
`define IDX_CLAMP        10'h034
`define IDX_RSVD_A       10'h035
`define IDX_RSVD_B       10'h036
`define IDX_RSVD_C       10'h037
`define IDX_IRQ_STATUS   10'h038
`define IDX_IRQ_MASK     10'h039

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_RCVR_ON      7
`define BIT_PROC_ON      6
`define BIT_EDGE_CLR     5
`define BIT_MARG_CLR     4
`define BIT_CTRL_RSVD    3
`define BIT_EDGE_FLAG    7
`define BIT_MARG_FLAG    6
`define IRQ_EDGE         0
`define IRQ_MARG         1

// ----------------------------------------
// reset values and control write mask
// ----------------------------------------
`define RST_TRIM_HIGH    7'h40
`define RST_TRIM_LOW     8'h00
`define RST_CLK_CTRL     8'hc0
`define RST_REF_DELAY    8'h80
`define RST_ANALOG_MISC_CONTROL     8'hc3
`define RST_CLAMP        8'h2f
`define RST_RSVD_A       8'hdf
`define RST_RSVD_B       8'h00
`define RST_RSVD_C       8'h45
`define STATUS_RSVD      6'h07
`define TRIM_NEUTRAL     15'h4000
`define CTRL_WMASK       8'hf7

`endif

//--- common/sysref_pkg.sv
// types shared by the reference capture register bank
// assumes the constants header for all figures
package sysref_pkg;

  // ----------------------------------------
  // capture front end state
  // ----------------------------------------
  typedef struct packed {
    logic main_s1;   // first sync stage, main pin
    logic main_s2;   // second sync stage
    logic main_s3;   // previous synced value
    logic tap_s1;    // first sync stage, delayed tap
    logic tap_s2;    // second sync stage
    logic tap_s3;    // previous synced value
    logic rise;      // registered rising-edge pulse
    logic marginal;  // registered marginal pulse
  } capture_t;

  // ----------------------------------------
  // register bank state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;        // clock generator control
    logic [6:0]  trim_high;   // trim word bits 14-8
    logic [7:0]  trim_low;    // trim word bits 7-0
    logic [7:0]  ref_delay;   // reference delay control
    logic [7:0]  analog_misc_control;    // analog miscellany
    logic [7:0]  clamp;       // input clamp control
    logic        edge_seen;   // sticky edge flag
    logic        marginal;    // sticky marginal flag
    logic [1:0]  irq_status;  // sticky event bits
    logic [1:0]  irq_mask;    // event enables
    logic        irq;         // interrupt output
    logic        ack;         // bus acknowledge
    logic [31:0] rdata;       // bus read data
    logic [14:0] trim_out;    // trim applied to converter
  } regs_t;

endpackage : sysref_pkg

//--- common/capture_if.sv
// carrier between the register bank and its capture front end
// assumes both ends share clk
`timescale 1ns/1ns
interface capture_if;
  logic enable;    // capture path powered and running
  logic rise;      // one-cycle rising edge pulse
  logic marginal;  // marginal capture pulse, two cycles when the copies sync a cycle apart

  modport bank  (output enable, input rise, input marginal);
  modport sense (input enable, output rise, output marginal);
endinterface : capture_if

//--- verilog/edge_capture.sv
// reference input synchroniser and edge classifier
// assumes asynchronous reference pin and a delayed tap of the same pin
`timescale 1ns/1ns
`include "sysref_consts.svh"
module edge_capture
  import sysref_pkg::*;
(
  input  wire logic clk,           // device clock
  input  wire logic rst_b,         // async reset, active low
  input  wire logic reference_in,  // reference pin
  input  wire logic tap_in,        // reference after short delay
  capture_if.sense  cap            // to the register bank
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  capture_t st;       // registered state
  capture_t next_st;  // next state

  assign cap.rise     = st.rise;
  assign cap.marginal = st.marginal;

  // next state: two-stage sync, then edge compare
  always_comb begin
    next_st         = st;
    next_st.main_s1 = reference_in;
    next_st.main_s2 = st.main_s1;
    next_st.main_s3 = st.main_s2;
    next_st.tap_s1  = tap_in;
    next_st.tap_s2  = st.tap_s1;
    next_st.tap_s3  = st.tap_s2;
    // edge only counted while receiver and processor run
    next_st.rise    = cap.enable & st.main_s2 & ~st.main_s3;
    // tap and main disagree on the edge cycle: near clock edge
    next_st.marginal = cap.enable &
                       ((st.main_s2 & ~st.main_s3) ^ (st.tap_s2 & ~st.tap_s3));
  end

  // register the state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : edge_capture

//--- verilog/sysref_capture_offset_regs.sv
// register bank for reference capture control and offset trim
// assumes a classic wishbone master on clk; reference pins are asynchronous, background_cal_active is on clk
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "sysref_consts.svh"
module sysref_capture_offset_regs
  import sysref_pkg::*;
(
  input  wire logic        clk,                      // device clock, 100 MHz
  input  wire logic        rst_b,                    // async reset, active low
  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  input  wire logic        wb_cyc_i,                 // bus cycle
  input  wire logic        wb_stb_i,                 // strobe
  input  wire logic        wb_we_i,                  // write enable
  input  wire logic [11:0] wb_adr_i,                 // byte address
  input  wire logic [3:0]  wb_sel_i,                 // byte lanes
  input  wire logic [31:0] wb_dat_i,                 // write data
  output logic      [31:0] wb_dat_o,                 // read data
  output logic             wb_ack_o,                 // acknowledge
  // ----------------------------------------
  // reference pins and calibration state
  // ----------------------------------------
  input  wire logic        reference_in,             // reference pin
  input  wire logic        reference_tap_in,         // delayed reference copy
  input  wire logic        background_cal_active,    // calibration mode, same clock
  // ----------------------------------------
  // controls to the analog section, and the interrupt
  // ----------------------------------------
  output logic             reference_receiver_on,    // receiver enable
  output logic             reference_processor_on,   // processor enable
  output logic             sample_clock_dc_coupled,  // sample clock coupling
  output logic             reference_dc_coupled,     // reference coupling
  output logic             timestamp_dc_coupled,     // timestamp coupling
  output logic      [14:0] global_offset_trim,       // trim applied to all banks
  output logic      [3:0]  reference_delay,          // reference delay steps
  output logic             interrupt                 // level, unmasked event pending
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // byte address to register index
  function automatic logic [9:0] reg_index(input logic [11:0] adr);
    reg_index = adr[11:2];
  endfunction : reg_index

  // lane 0 write of one byte
  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [7:0] wdat,
                                            input logic       lane);
    merge_byte = lane ? wdat : old;
  endfunction : merge_byte

  // control bit written from one to zero
  function automatic logic fell(input logic [7:0] old,
                                input logic [7:0] nxt,
                                input int         pos);
    fell = old[pos] & ~nxt[pos];
  endfunction : fell

  // ----------------------------------------
  // state and front end
  // ----------------------------------------
  regs_t      st;        // registered state
  regs_t      next_st;   // next state
  capture_if  cap ();    // front end carrier

  edge_capture u_capture (
    .clk          (clk),
    .rst_b        (rst_b),
    .reference_in (reference_in),
    .tap_in       (reference_tap_in),
    .cap          (cap.sense)
  );

  // capture runs only with both stages powered
  assign cap.enable = st.ctrl[`BIT_RCVR_ON] & st.ctrl[`BIT_PROC_ON];

  // ----------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------
  assign wb_dat_o                = st.rdata;
  assign wb_ack_o                = st.ack;
  assign reference_receiver_on   = st.ctrl[`BIT_RCVR_ON];
  assign reference_processor_on  = st.ctrl[`BIT_PROC_ON];
  assign sample_clock_dc_coupled = st.ctrl[2];
  assign reference_dc_coupled    = st.ctrl[1];
  assign timestamp_dc_coupled    = st.ctrl[0];
  assign global_offset_trim      = st.trim_out;
  assign reference_delay         = st.ref_delay[3:0];
  assign interrupt               = st.irq;

  // ----------------------------------------
  // next state
  // ----------------------------------------

  // bus decode, register writes, flags, interrupt
  always_comb begin
    logic        req;       // new request this cycle
    logic        wr;        // write taken now
    logic [9:0]  idx;       // decoded index
    logic [7:0]  wbyte;     // lane 0 write byte
    logic [7:0]  ctrl_new;  // control after this write
    logic        clr_edge;  // edge clear sequence done
    logic        clr_marg;  // marginal clear sequence done
    logic [1:0]  events;    // events this cycle
    logic [1:0]  w1c;       // status bits written one

    req      = wb_cyc_i & wb_stb_i & ~st.ack;
    wr       = req & wb_we_i;
    idx      = reg_index(wb_adr_i);
    wbyte    = wb_dat_i[7:0];
    ctrl_new = st.ctrl;
    clr_edge = 1'b0;
    clr_marg = 1'b0;
    w1c      = 2'b00;
    next_st  = st;

    // one-cycle acknowledge, dropped the cycle after
    next_st.ack = req;

    // register writes; only lane 0 carries data
    if (wr) begin
      unique case (idx)
        `IDX_TRIM_HIGH: begin
          next_st.trim_high = merge_byte({1'b0, st.trim_high}, wbyte, wb_sel_i[0])
                              [6:0];
        end
        `IDX_TRIM_LOW: begin
          next_st.trim_low = merge_byte(st.trim_low, wbyte, wb_sel_i[0]);
        end
        `IDX_CLK_CTRL: begin
          // reserved bit 3 stays zero whatever is written
          ctrl_new     = merge_byte(st.ctrl, wbyte & `CTRL_WMASK,
                                    wb_sel_i[0]);
          next_st.ctrl = ctrl_new;
        end
        `IDX_REF_DELAY: begin
          next_st.ref_delay = merge_byte(st.ref_delay, wbyte, wb_sel_i[0]);
        end
        `IDX_ANALOG_MISC_CONTROL: begin
          next_st.analog_misc_control = merge_byte(st.analog_misc_control, wbyte, wb_sel_i[0]);
        end
        `IDX_CLAMP: begin
          next_st.clamp = merge_byte(st.clamp, wbyte, wb_sel_i[0]);
        end
        `IDX_IRQ_STATUS: begin
          // write one clears the sticky bit
          w1c = wb_sel_i[0] ? wbyte[1:0] : 2'b00;
        end
        `IDX_IRQ_MASK: begin
          if (wb_sel_i[0]) begin
            next_st.irq_mask = wbyte[1:0];
          end
        end
        default: begin
          // status, reserved and unmapped indices ignore writes
        end
      endcase
    end

    // clear happens when the bit goes back from one to zero
    clr_edge = fell(st.ctrl, ctrl_new, `BIT_EDGE_CLR);
    clr_marg = fell(st.ctrl, ctrl_new, `BIT_MARG_CLR);

    // sticky capture flags; a new event wins over the clear
    events = {cap.marginal, cap.rise};
    if (cap.rise) begin
      next_st.edge_seen = 1'b1;
    end else if (clr_edge) begin
      next_st.edge_seen = 1'b0;
    end
    if (cap.marginal) begin
      next_st.marginal = 1'b1;
    end else if (clr_marg) begin
      next_st.marginal = 1'b0;
    end

    // interrupt status: set wins over write-one clear
    next_st.irq_status = (st.irq_status & ~w1c) | events;
    next_st.irq        = |(next_st.irq_status & next_st.irq_mask);

    // trim word; neutral while background calibration owns offset
    if (background_cal_active) begin
      next_st.trim_out = `TRIM_NEUTRAL;
    end else begin
      next_st.trim_out = {next_st.trim_high, next_st.trim_low};
    end

    // read data, captured with the acknowledge
    next_st.rdata = st.rdata;
    if (req) begin
      next_st.rdata = 32'h0000_0000;
      if (!wb_we_i) begin
        unique case (idx)
          `IDX_TRIM_HIGH:  next_st.rdata[7:0] = {1'b0, st.trim_high};
          `IDX_TRIM_LOW:   next_st.rdata[7:0] = st.trim_low;
          `IDX_CLK_CTRL:   next_st.rdata[7:0] = st.ctrl;
          `IDX_CLK_STATUS: begin
            // fixed reserved pattern below the two flags
            next_st.rdata[7:0] = {st.edge_seen, st.marginal,
                                  `STATUS_RSVD};
          end
          `IDX_REF_DELAY:  next_st.rdata[7:0] = st.ref_delay;
          `IDX_ANALOG_MISC_CONTROL:   next_st.rdata[7:0] = st.analog_misc_control;
          `IDX_CLAMP:      next_st.rdata[7:0] = st.clamp;
          `IDX_RSVD_A:     next_st.rdata[7:0] = `RST_RSVD_A;
          `IDX_RSVD_B:     next_st.rdata[7:0] = `RST_RSVD_B;
          `IDX_RSVD_C:     next_st.rdata[7:0] = `RST_RSVD_C;
          `IDX_IRQ_STATUS: next_st.rdata[1:0] = st.irq_status;
          `IDX_IRQ_MASK:   next_st.rdata[1:0] = st.irq_mask;
          default: begin
            // unmapped index reads zero
            next_st.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------

  // reset to documented defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.ctrl       <= `RST_CLK_CTRL;
      st.trim_high  <= `RST_TRIM_HIGH;
      st.trim_low   <= `RST_TRIM_LOW;
      st.ref_delay  <= `RST_REF_DELAY;
      st.analog_misc_control   <= `RST_ANALOG_MISC_CONTROL;
      st.clamp      <= `RST_CLAMP;
      st.trim_out   <= `TRIM_NEUTRAL;
    end else begin
      st <= next_st;
    end
  end

endmodule : sysref_capture_offset_regs

//--- verif/ref_source.sv
// behavioural reference source at the far side of the capture pins
// assumes fire and skew come from the bench clock domain
`timescale 1ns/1ns
module ref_source (
  input  wire logic clk,      // bench clock
  input  wire logic fire,     // request one reference pulse
  input  wire logic skew,     // late tap copy, marginal capture
  output logic      ref_pin,  // reference pin
  output logic      tap_pin   // delayed copy of the pin
);
  // pins stand low between pulses
  initial begin
    ref_pin = 1'b0;
    tap_pin = 1'b0;
  end
  // edge lands 3 ns after the clock edge; no timing sweeps
  always @(posedge clk) begin
    if (fire) begin
      #3 ref_pin = 1'b1;
      if (skew) begin
        #10 tap_pin = 1'b1;  // copies disagree
      end else begin
        tap_pin = 1'b1;
      end
      #60 ref_pin = 1'b0;
      tap_pin = 1'b0;
    end
  end
endmodule : ref_source

//--- verif/sysref_regs_chk.sv
// port checks for the reference capture register bank
// assumes one clock domain and a classic wishbone master
`timescale 1ns/1ns
`include "sysref_consts.svh"
module sysref_regs_chk (
  input wire logic        clk,                      // device clock
  input wire logic        rst_b,                    // async reset, active low
  input wire logic        wb_cyc_i,                 // bus cycle
  input wire logic        wb_stb_i,                 // strobe
  input wire logic        wb_we_i,                  // write enable
  input wire logic [11:0] wb_adr_i,                 // byte address
  input wire logic [3:0]  wb_sel_i,                 // byte lanes
  input wire logic [31:0] wb_dat_i,                 // write data
  input wire logic [31:0] wb_dat_o,                 // read data
  input wire logic        wb_ack_o,                 // acknowledge
  input wire logic        reference_in,             // reference pin
  input wire logic        reference_tap_in,         // delayed copy
  input wire logic        background_cal_active,    // calibration mode
  input wire logic        reference_receiver_on,    // receiver enable
  input wire logic        reference_processor_on,   // processor enable
  input wire logic        sample_clock_dc_coupled,  // sample clock coupling
  input wire logic        reference_dc_coupled,     // reference coupling
  input wire logic        timestamp_dc_coupled,     // timestamp coupling
  input wire logic [14:0] global_offset_trim,       // applied trim
  input wire logic [3:0]  reference_delay,          // delay steps
  input wire logic        interrupt                 // level interrupt
);
  logic take;     // request taken at this edge
  logic wr_ctrl;  // control write taken
  logic wr_low;   // trim low write taken
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = take && wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == `IDX_CLK_CTRL;
  assign wr_low = take && wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == `IDX_TRIM_LOW;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ack_timing_a: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  receiver_set_a: assert property (wr_ctrl |-> ##2 reference_receiver_on == $past(wb_dat_i[7], 2))
    else $error("receiver enable not as written");
  processor_set_a: assert property (wr_ctrl |-> ##2 reference_processor_on == $past(wb_dat_i[6], 2))
    else $error("processor enable not as written");
  coupling_set_a: assert property (wr_ctrl |-> ##2 {sample_clock_dc_coupled, reference_dc_coupled,
    timestamp_dc_coupled} == $past(wb_dat_i[2:0], 2))
    else $error("coupling bits not as written");
  trim_low_a: assert property ((wr_low && !background_cal_active) ##1 !background_cal_active[*2]
    |-> global_offset_trim[7:0] == $past(wb_dat_i[7:0], 2))
    else $error("trim low byte not applied");
  trim_cal_a: assert property (background_cal_active |=> global_offset_trim == `TRIM_NEUTRAL)
    else $error("trim applied during calibration");
  status_fixed_a: assert property (take && !wb_we_i && wb_adr_i[11:2] == `IDX_CLK_STATUS
    |=> wb_dat_o[5:0] == `STATUS_RSVD && wb_dat_o[31:8] == '0)
    else $error("status reserved bits wrong");
  ctrl_rsvd_a: assert property (take && !wb_we_i && wb_adr_i[11:2] == `IDX_CLK_CTRL
    |=> !wb_dat_o[3])
    else $error("control reserved bit set");
endmodule : sysref_regs_chk
bind sysref_capture_offset_regs sysref_regs_chk u_chk (.clk(clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .reference_in(reference_in), .reference_tap_in(reference_tap_in),
  .background_cal_active(background_cal_active), .reference_receiver_on(reference_receiver_on),
  .reference_processor_on(reference_processor_on),
  .sample_clock_dc_coupled(sample_clock_dc_coupled), .reference_dc_coupled(reference_dc_coupled),
  .timestamp_dc_coupled(timestamp_dc_coupled), .global_offset_trim(global_offset_trim),
  .reference_delay(reference_delay), .interrupt(interrupt));

//--- verif/testbench.sv
// self-checking bench for the reference capture register bank
// assumes the ref_source model on the pins and a 100 MHz clock
`timescale 1ns/1ns
`include "sysref_consts.svh"
module testbench;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, rdel;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cal, fire, skew;
  logic        ref_pin, tap_pin, rcv_on, proc_on, clk_dc, ref_dc, ts_dc, interrupt;
  logic [14:0] trim;
  logic [7:0]  q, d, hi, lo;
  int          num_errors, total_checks, seed;
  localparam logic [9:0] ridx [12] = '{`IDX_TRIM_HIGH, `IDX_TRIM_LOW, `IDX_CLK_CTRL,
    `IDX_CLK_STATUS, `IDX_REF_DELAY, `IDX_ANALOG_MISC_CONTROL, `IDX_CLAMP, `IDX_RSVD_A, `IDX_RSVD_B,
    `IDX_RSVD_C, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
  localparam logic [7:0] rval [12] = '{8'h40, 8'h00, 8'hc0, 8'h07, 8'h80, 8'hc3, 8'h2f,
    8'hdf, 8'h00, 8'h45, 8'h00, 8'h00};
  sysref_capture_offset_regs u_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reference_in(ref_pin),
    .reference_tap_in(tap_pin), .background_cal_active(cal), .reference_receiver_on(rcv_on),
    .reference_processor_on(proc_on), .sample_clock_dc_coupled(clk_dc),
    .reference_dc_coupled(ref_dc), .timestamp_dc_coupled(ts_dc), .global_offset_trim(trim),
    .reference_delay(rdel), .interrupt(interrupt));
  ref_source u_src (.clk(clk), .fire(fire), .skew(skew), .ref_pin(ref_pin), .tap_pin(tap_pin));
  always #5 clk = ~clk;  // 100 MHz
  // compare and count
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one classic wishbone cycle, then one idle cycle
  task automatic wb(input logic [9:0] idx, input logic we, input logic [7:0] wd,
                    input logic [3:0] s);
    int n;
    n = 0;
    wb_adr_i <= {idx, 2'b00};
    wb_we_i <= we;
    wb_sel_i <= s;
    wb_dat_i <= {24'h00_0000, wd};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    wb(idx, 1'b1, wd, 4'h1);
  endtask : wr
  task automatic rchk(input string nm, input logic [9:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00, 4'h1);
    check(nm, 16'(exp), 16'(q));
  endtask : rchk
  // one reference pulse from the far side
  task automatic pulse(input logic sk);
    skew <= sk;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse
  function automatic logic [14:0] exp_trim(input logic [7:0] h, l, input logic c);
    return c ? `TRIM_NEUTRAL : {h[6:0], l};
  endfunction : exp_trim
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // watchdog
  initial begin
    #200000;
    num_errors++;
    results();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, cal, fire, skew} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    seed = 76983;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("trim_rst", 16'(`TRIM_NEUTRAL), 16'(trim));
    check("enables", 16'h0003, {14'h0000, rcv_on, proc_on});
    check("coupling", 16'h0000, {13'h0000, clk_dc, ref_dc, ts_dc});
    for (int i = 0; i < 12; i++) rchk("reset", ridx[i], rval[i]);
    for (int i = 3; i < 10; i++) begin
      d = 8'($random(seed));
      wr(ridx[i], d);
      if (i > 3 && i < 7) rchk("stored", ridx[i], d);
      else rchk("read_only", ridx[i], rval[i]);
      if (i == 4) check("delay", 16'(d[3:0]), 16'(rdel));
    end
    wr(10'h0ff, 8'hff);
    rchk("unmapped", 10'h0ff, 8'h00);
    wb(`IDX_TRIM_LOW, 1'b1, 8'h55, 4'he);
    rchk("lane", `IDX_TRIM_LOW, 8'h00);
    for (int i = 0; i < 10; i++) begin
      hi = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($random(seed));
      lo = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      cal <= (i > 6);
      wr(`IDX_TRIM_HIGH, hi);
      wr(`IDX_TRIM_LOW, lo);
      check("trim", 16'(exp_trim(hi, lo, i > 6)), 16'(trim));
      rchk("trim_low", `IDX_TRIM_LOW, lo);
    end
    cal <= 1'b0;
    repeat (3) @(posedge clk);
    check("trim_back", 16'(exp_trim(hi, lo, 1'b0)), 16'(trim));
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed)) & 8'h0f | 8'hc8;
      wr(`IDX_CLK_CTRL, d);
      rchk("ctrl", `IDX_CLK_CTRL, d & `CTRL_WMASK);
      check("coupling", 16'(d[2:0]), {13'h0000, clk_dc, ref_dc, ts_dc});
    end
    wr(`IDX_CLK_CTRL, 8'h80);  // processor off first
    check("proc_off", 16'h0002, {14'h0000, rcv_on, proc_on});
    wr(`IDX_CLK_CTRL, 8'h00);  // then receiver
    check("rcv_off", 16'h0000, {14'h0000, rcv_on, proc_on});
    pulse(1'b0);
    rchk("disabled", `IDX_CLK_STATUS, 8'h07);
    wr(`IDX_CLK_CTRL, 8'h80);  // receiver on first
    wr(`IDX_CLK_CTRL, 8'hc0);  // then processor
    wr(`IDX_IRQ_MASK, 8'h03);
    pulse(1'b0);
    rchk("edge", `IDX_CLK_STATUS, 8'h87);
    check("irq_on", 16'h0001, 16'(interrupt));
    pulse(1'b0);
    wr(`IDX_CLK_CTRL, 8'he0);
    rchk("edge_hold", `IDX_CLK_STATUS, 8'h87);
    wr(`IDX_CLK_CTRL, 8'hc0);
    rchk("edge_clr", `IDX_CLK_STATUS, 8'h07);
    rchk("irq_st", `IDX_IRQ_STATUS, 8'h01);
    wr(`IDX_IRQ_STATUS, 8'h01);
    check("irq_clr", 16'h0000, 16'(interrupt));
    pulse(1'b1);
    wb(`IDX_CLK_STATUS, 1'b0, 8'h00, 4'h1);
    check("marg", 16'h0040, 16'(q & 8'h40));
    check("irq_marg", 16'h0001, 16'(interrupt));
    wr(`IDX_CLK_CTRL, 8'hd0);
    wr(`IDX_CLK_CTRL, 8'hc0);
    wb(`IDX_CLK_STATUS, 1'b0, 8'h00, 4'h1);
    check("marg_clr", 16'h0000, 16'(q & 8'h40));
    wr(`IDX_IRQ_MASK, 8'h00);
    wr(`IDX_IRQ_STATUS, 8'h03);
    pulse(1'b0);
    check("irq_mask", 16'h0000, 16'(interrupt));
    rchk("irq_pend", `IDX_IRQ_STATUS, 8'h01);
    wr(`IDX_IRQ_MASK, 8'h01);
    check("irq_unmask", 16'h0001, 16'(interrupt));
    results();
  end
endmodule : testbench
